// *** verilog/fbp_pkg.sv ***
/*
  Package for the flash block protection logic: register offsets, field
  positions, reset values, fixed flash addresses and the sequence states.
  Assumes a 16-bit flash address space whose top location is FFFF.
*/
package fbp_pkg;

    // register byte offsets on the APB slave
    localparam logic [11:0] FBP_OFS_CTRL = 12'h000;
    localparam logic [11:0] FBP_OFS_PROTECT = 12'h004;
    localparam logic [11:0] FBP_OFS_STATUS = 12'h008;
    localparam logic [11:0] FBP_OFS_ARM_ADDR = 12'h00C;

    // control register fields
    localparam int FBP_CTRL_PGM = 0;
    localparam int FBP_CTRL_ERS = 1;
    localparam int FBP_CTRL_MASS = 2;
    localparam int FBP_CTRL_HIGH_VOLTAGE_ENABLE = 3;

    // status register fields
    localparam int FBP_ST_REFUSED = 0;
    localparam int FBP_ST_ARMED = 1;
    localparam int FBP_ST_STATE_LO = 2;
    localparam int FBP_ST_WHOLE = 5;
    localparam int FBP_ST_START_LO = 16;

    // flash layout
    localparam logic [15:0] FBP_FLASH_TOP = 16'hFFFF;
    localparam logic [15:0] FBP_FLASH_BOTTOM = 16'hDE00;
    localparam logic [15:0] FBP_PROTECT_BYTE_ADDR = 16'hFFBE;
    localparam logic [7:0] FBP_BYTE_ERASED = 8'hFF;
    localparam logic [7:0] FBP_BYTE_ALL_ZERO = 8'h00;
    localparam logic [1:0] FBP_START_HIGH_BITS = 2'h3;
    localparam logic [5:0] FBP_START_LOW_BITS = 6'h00;

    // reset values
    localparam logic [15:0] FBP_ARM_ADDR_RESET = 16'h0000;
    localparam logic [31:0] FBP_RDATA_RESET = 32'h00000000;

    // program / erase sequence, gray coded along the usual path
    typedef enum logic [2:0] {
        FBP_IDLE = 3'h0,
        FBP_SELECTED = 3'h1,
        FBP_CHECKED = 3'h3,
        FBP_ARMED = 3'h2,
        FBP_HV_ON = 3'h6
    } fbp_state_e;

endpackage : fbp_pkg

// *** verilog/fbp_start_addr.sv ***
/*
  Expands the stored protect byte into the 16-bit protect start address.
  Assumes the byte is the live value read from the flash array.
*/
`timescale 1ns/1ps
module fbp_start_addr
    import fbp_pkg::*;
(
    input wire logic [7:0] protectByte, // live stored protect byte
    output logic [15:0] startAddr, // first protected address
    output logic wholeArray // start at or below flash bottom
);

    // byte forms bits 13:6, so the start is always 64-byte aligned
    assign startAddr = {FBP_START_HIGH_BITS, protectByte, FBP_START_LOW_BITS};
    assign wholeArray = (protectByte != FBP_BYTE_ERASED)
        && (startAddr <= FBP_FLASH_BOTTOM);

endmodule : fbp_start_addr

// *** verilog/fbp_guard.sv ***
/*
  Decides whether high voltage may be applied for the armed target.
  Assumes the target address was latched by the arming write.
*/
`timescale 1ns/1ps
module fbp_guard
    import fbp_pkg::*;
(
    input wire logic [15:0] targetAddr, // latched arming address
    input wire logic [7:0] protectByte, // live stored protect byte
    input wire logic [15:0] startAddr, // expanded protect start
    input wire logic eraseSel, // erase selected
    input wire logic massSel, // mass erase selected
    input wire logic testHighVoltage, // test voltage present on irq pin
    output logic allowed // high voltage may be enabled
);

    logic byteErased;
    logic hitsByte;

    assign byteErased = (protectByte == FBP_BYTE_ERASED);
    // a page erase touches the byte when the page holds it
    assign hitsByte = eraseSel ? (targetAddr[15:6] == FBP_PROTECT_BYTE_ADDR[15:6])
                               : (targetAddr == FBP_PROTECT_BYTE_ADDR);

    always_comb begin
        if (massSel && eraseSel) begin
            allowed = byteErased;
        end else if (hitsByte) begin
            allowed = testHighVoltage;
        end else if (byteErased) begin
            allowed = 1'b1;
        end else if (protectByte == FBP_BYTE_ALL_ZERO) begin
            allowed = 1'b0;
        end else begin
            allowed = (targetAddr < startAddr);
        end
    end

endmodule : fbp_guard

// *** verilog/fbp_flash_protect.sv ***
/*
  Flash program / erase control with block protection, reached over APB.
  Holds the selection bits, tracks the sequence (select, protect read,
  arming write, high voltage) and refuses high voltage on targets protected under the selection held before the requesting write.
  Assumes the flash array supplies its stored protect byte continuously and
  reports CPU writes into the flash range as one-cycle strobes.
*/
`timescale 1ns/1ps

module fbp_flash_protect
    import fbp_pkg::*;
(
    input wire logic mclk, // bus clock
    input wire logic reset, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 = write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [7:0] protectByte, // stored protect byte from the array
    input wire logic flashWrite, // cpu write into the flash range
    input wire logic [15:0] flashAddr, // address of that write
    input wire logic testHighVoltage, // test voltage detected on irq pin
    output logic programSelect, // program operation selected
    output logic eraseSelect, // erase operation selected
    output logic massSelect, // mass erase selected
    output logic highVoltageEnable, // charge pump and array high voltage
    output logic monitorEntryOk // reset may enter monitor mode
);

    typedef struct packed {
        logic program_select;
        logic ers;
        logic mass;
        logic hv;
        fbp_state_e state;
        logic [15:0] armAddr;
        logic refused;
        logic [31:0] rdata;
        logic slvErr;
        logic monitorOk;
    } fbp_regs_s;

    fbp_regs_s regs_r;
    fbp_regs_s regs_nxt;

    logic [15:0] startAddr;
    logic wholeArray;
    logic allowed;
    logic setupPhase;
    logic accessWrite;
    logic accessRead;
    logic ctrlWrite;
    logic hvRequest;
    logic hvRefuse;
    logic [31:0] rdMux;
    logic rdMapped;

    fbp_start_addr uStart (
        .protectByte(protectByte),
        .startAddr(startAddr),
        .wholeArray(wholeArray)
    );

    // the live byte is used on purpose: reprogramming under test voltage
    // takes effect without a reset
    fbp_guard uGuard (
        .targetAddr(regs_r.armAddr),
        .protectByte(protectByte),
        .startAddr(startAddr),
        .eraseSel(regs_r.ers),
        .massSel(regs_r.mass),
        .testHighVoltage(testHighVoltage),
        .allowed(allowed)
    );

    assign setupPhase = psel && !penable;
    assign accessWrite = psel && penable && pwrite;
    assign accessRead = psel && penable && !pwrite;
    assign ctrlWrite = accessWrite && (paddr == FBP_OFS_CTRL);
    assign hvRequest = ctrlWrite && pwdata[FBP_CTRL_HIGH_VOLTAGE_ENABLE] && !regs_r.hv;
    assign hvRefuse = hvRequest && !((regs_r.state == FBP_ARMED) && allowed);

    // read data is captured in the setup cycle so prdata comes from flops
    always_comb begin
        rdMux = 32'h00000000;
        rdMapped = 1'b1;
        unique case (paddr)
            FBP_OFS_CTRL: begin
                rdMux[FBP_CTRL_PGM] = regs_r.program_select;
                rdMux[FBP_CTRL_ERS] = regs_r.ers;
                rdMux[FBP_CTRL_MASS] = regs_r.mass;
                rdMux[FBP_CTRL_HIGH_VOLTAGE_ENABLE] = regs_r.hv;
            end
            FBP_OFS_PROTECT: begin
                rdMux[7:0] = protectByte;
            end
            FBP_OFS_STATUS: begin
                rdMux[FBP_ST_REFUSED] = regs_r.refused;
                rdMux[FBP_ST_ARMED] = (regs_r.state == FBP_ARMED);
                rdMux[FBP_ST_STATE_LO +: 3] = regs_r.state;
                rdMux[FBP_ST_WHOLE] = wholeArray;
                rdMux[FBP_ST_START_LO +: 16] = startAddr;
            end
            FBP_OFS_ARM_ADDR: begin
                rdMux[15:0] = regs_r.armAddr;
            end
            default: begin
                rdMapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.monitorOk = testHighVoltage;
        if (setupPhase) begin
            regs_nxt.rdata = pwrite ? FBP_RDATA_RESET : rdMux;
            regs_nxt.slvErr = !rdMapped;
        end

        // writes to the protect byte offset are accepted but change nothing
        if (ctrlWrite) begin
            regs_nxt.mass = pwdata[FBP_CTRL_MASS];
            // a write asking for both selections keeps the old pair
            if (!(pwdata[FBP_CTRL_PGM] && pwdata[FBP_CTRL_ERS])) begin
                regs_nxt.program_select = pwdata[FBP_CTRL_PGM];
                regs_nxt.ers = pwdata[FBP_CTRL_ERS];
            end
            if (!pwdata[FBP_CTRL_HIGH_VOLTAGE_ENABLE]) begin
                regs_nxt.hv = 1'b0;
            end else if (hvRequest && !hvRefuse) begin
                regs_nxt.hv = 1'b1;
            end
        end

        // refusal sets the sticky flag; a write of one clears it, set wins
        if (accessWrite && (paddr == FBP_OFS_STATUS) && pwdata[FBP_ST_REFUSED]) begin
            regs_nxt.refused = 1'b0;
        end
        if (hvRefuse) begin
            regs_nxt.refused = 1'b1;
        end

        unique case (regs_r.state)
            FBP_IDLE: begin
                if (regs_nxt.program_select || regs_nxt.ers) begin
                    regs_nxt.state = FBP_SELECTED;
                end
            end
            FBP_SELECTED, FBP_CHECKED, FBP_ARMED: begin
                if (!(regs_nxt.program_select || regs_nxt.ers)) begin
                    regs_nxt.state = FBP_IDLE;
                end else if (regs_nxt.hv) begin
                    regs_nxt.state = FBP_HV_ON;
                end else if (regs_r.state == FBP_SELECTED && accessRead
                        && paddr == FBP_OFS_PROTECT) begin
                    regs_nxt.state = FBP_CHECKED;
                end else if (regs_r.state == FBP_CHECKED && flashWrite) begin
                    regs_nxt.armAddr = flashAddr;
                    regs_nxt.state = FBP_ARMED;
                end
            end
            FBP_HV_ON: begin
                if (!regs_nxt.hv) begin
                    regs_nxt.state = (regs_nxt.program_select || regs_nxt.ers) ? FBP_SELECTED : FBP_IDLE;
                end
            end
            default: begin
                regs_nxt.state = FBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            regs_r.program_select <= 1'b0;
            regs_r.ers <= 1'b0;
            regs_r.mass <= 1'b0;
            regs_r.hv <= 1'b0;
            regs_r.state <= FBP_IDLE;
            regs_r.armAddr <= FBP_ARM_ADDR_RESET;
            regs_r.refused <= 1'b0;
            regs_r.rdata <= FBP_RDATA_RESET;
            regs_r.slvErr <= 1'b0;
            regs_r.monitorOk <= 1'b0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    assign prdata = regs_r.rdata;
    assign pslverr = regs_r.slvErr && psel && penable;
    assign pready = 1'b1;
    assign programSelect = regs_r.program_select;
    assign eraseSelect = regs_r.ers;
    assign massSelect = regs_r.mass;
    assign highVoltageEnable = regs_r.hv;
    assign monitorEntryOk = regs_r.monitorOk;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property hvRisesOnlyWhenArmed;
        $rose(regs_r.hv) |-> $past(regs_r.state) == FBP_ARMED && $past(allowed);
    endproperty

    chk_hv_armed_only: assert property (hvRisesOnlyWhenArmed)
        else $error("high voltage rose without armed allowed target");

    chk_select_interlock: assert property (!(regs_r.program_select && regs_r.ers))
        else $error("program and erase selected together");

    chk_mass_locked: assert property (
        $rose(regs_r.hv) && regs_r.mass && regs_r.ers |-> $past(protectByte) == FBP_BYTE_ERASED)
        else $error("mass erase high voltage while a block is protected");

    chk_byte_needs_vtst: assert property (
        $rose(regs_r.hv) && regs_r.program_select && regs_r.armAddr == FBP_PROTECT_BYTE_ADDR
        |-> $past(testHighVoltage))
        else $error("protect byte programmed without test voltage");

    chk_zero_locks_all: assert property (
        $rose(regs_r.hv) && !$past(testHighVoltage) |-> $past(protectByte) != FBP_BYTE_ALL_ZERO)
        else $error("high voltage accepted with all-zero protect byte");

    chk_range_refused: assert property (
        $rose(regs_r.hv) && !regs_r.mass && regs_r.armAddr[15:6] != FBP_PROTECT_BYTE_ADDR[15:6]
        && $past(protectByte) != FBP_BYTE_ERASED
        |-> regs_r.armAddr < {FBP_START_HIGH_BITS, $past(protectByte), FBP_START_LOW_BITS})
        else $error("high voltage accepted inside protected range");

    chk_start_aligned: assert property (
        startAddr[5:0] == FBP_START_LOW_BITS && startAddr[15:14] == FBP_START_HIGH_BITS)
        else $error("protect start address not aligned");

    chk_refused_sticky: assert property (hvRefuse |=> regs_r.refused && !regs_r.hv)
        else $error("refused request not flagged or high voltage set");

    chk_protect_readback: assert property (
        setupPhase && !pwrite && paddr == FBP_OFS_PROTECT
        |=> prdata == {24'h000000, $past(protectByte)})
        else $error("protect byte read does not show stored value");

    chk_arm_latch: assert property (
        regs_r.state == FBP_CHECKED && flashWrite && !ctrlWrite
        ##1 regs_r.state == FBP_ARMED |-> regs_r.armAddr == $past(flashAddr))
        else $error("arming address not latched");

    cov_program_hv: cover property (regs_r.program_select && $rose(regs_r.hv));
    cov_mass_hv: cover property (regs_r.mass && $rose(regs_r.hv));
    cov_refused: cover property (hvRefuse);
    cov_byte_vtst: cover property (testHighVoltage && $rose(regs_r.hv)
        && regs_r.armAddr == FBP_PROTECT_BYTE_ADDR);

endmodule : fbp_flash_protect

// *** tb/fbp_flash_model.sv ***
/*
  Model of the flash array side: holds the stored protect byte and issues
  one-cycle cpu write strobes into the flash range on request.
  Assumes the bench drives its requests by non-blocking assignment.
*/
`timescale 1ns/1ps
module fbp_flash_model (
    input wire logic mclk, // bus clock
    input wire logic reset, // async reset, active high
    input wire logic loadByte, // store newByte as protect byte
    input wire logic [7:0] newByte, // byte to store
    input wire logic armGo, // request one cpu write into flash
    input wire logic [15:0] armTarget, // address of that write
    output logic [7:0] protectByte, // stored protect byte
    output logic flashWrite, // one-cycle write strobe
    output logic [15:0] flashAddr // write address
);
    logic [15:0] lastAddr;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            protectByte <= 8'hFF;
            flashWrite <= 1'b0;
            lastAddr <= 16'h0000;
        end else begin
            if (loadByte) begin
                protectByte <= newByte;
            end
            flashWrite <= armGo;
            if (armGo) begin
                lastAddr <= armTarget;
            end
        end
    end
    // released bus shows the inverse so a stale address cannot pass unnoticed
    assign flashAddr = flashWrite ? lastAddr : ~lastAddr;
endmodule : fbp_flash_model

// *** tb/fbp_flash_protect_tb.sv ***
/*
  Self-checking bench for the flash protection block: APB master, flash
  model, expectation queue checked by a bus monitor.
  Assumes zero or more wait states; waits on pready.
*/
`timescale 1ns/1ps
module fbp_flash_protect_tb import fbp_pkg::*;;
    typedef struct {logic [31:0] m; logic [31:0] d; logic e;} fbp_exp_s;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] protectByte, newByte, b;
    logic flashWrite, loadByte, armGo, tv, pgmO, ersO, massO, hvO, monO;
    logic [15:0] flashAddr, armTarget, t;
    fbp_exp_s expQ[$];
    fbp_exp_s x;
    int failures, checked, cycles;
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    fbp_flash_protect fbp_flash_protect_i (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .protectByte(protectByte),
        .flashWrite(flashWrite), .flashAddr(flashAddr), .testHighVoltage(tv),
        .programSelect(pgmO), .eraseSelect(ersO), .massSelect(massO),
        .highVoltageEnable(hvO), .monitorEntryOk(monO));
    fbp_flash_model fbp_flash_model_i (.mclk(mclk), .reset(reset), .loadByte(loadByte),
        .newByte(newByte), .armGo(armGo), .armTarget(armTarget),
        .protectByte(protectByte), .flashWrite(flashWrite), .flashAddr(flashAddr));
    task fail(input string s);
        failures++;
        $display("[ERR] %0t %s", $time, s);
    endtask : fail
    task chk(input logic got, input logic want, input string s);
        checked++;
        if (got !== want) fail(s);
    endtask : chk
    task results;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
              input logic [31:0] m, input logic [31:0] d, input logic e);
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        expQ.push_back('{m, d, e});
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 0;
        penable <= 0;
    endtask : xfer
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1, d, 32'h0, 32'h0, 0);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] d);
        xfer(a, 0, 32'h0, m, d, 0);
    endtask : rd
    task setByte(input logic [7:0] v);
        @(posedge mclk);
        loadByte <= 1;
        newByte <= v;
        @(posedge mclk);
        loadByte <= 0;
    endtask : setByte
    function automatic logic allowExp(input logic [7:0] bv, input logic [15:0] ta,
                                      input logic ers, input logic mass, input logic tvv);
        if (ers && mass) return bv == 8'hFF;
        if (ers ? ta[15:6] == FBP_PROTECT_BYTE_ADDR[15:6] : ta == FBP_PROTECT_BYTE_ADDR)
            return tvv;
        if (bv == 8'hFF) return 1'b1;
        if (bv == 8'h00) return 1'b0;
        return ta < {2'h3, bv, 6'h00};
    endfunction : allowExp
    task seq(input logic [7:0] bv, input logic [15:0] ta, input logic [3:0] sel,
             input logic tvv, input logic rdP, input logic [7:0] late);
        logic ok;
        setByte(bv);
        tv <= tvv;
        wr(FBP_OFS_CTRL, {28'h0, sel});
        if (rdP) rd(FBP_OFS_PROTECT, 32'hFF, {24'h0, bv});
        @(posedge mclk);
        armGo <= 1;
        armTarget <= ta;
        @(posedge mclk);
        armGo <= 0;
        setByte(late);
        ok = rdP && allowExp(late, ta, sel[1], sel[2], tvv);
        wr(FBP_OFS_CTRL, {28'h0, sel | 4'h8});
        rd(FBP_OFS_CTRL, 32'hF, {28'h0, ok, sel[2:0]});
        chk(hvO, ok, "high voltage level");
        chk(pgmO, sel[0], "program select level");
        chk(ersO, sel[1], "erase select level");
        chk(massO, sel[2], "mass select level");
        rd(FBP_OFS_STATUS, 32'h1, {31'h0, !ok});
        wr(FBP_OFS_CTRL, 32'h0);
        wr(FBP_OFS_STATUS, 32'h1);
        tv <= 0;
    endtask : seq
    always @(posedge mclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            x = expQ.pop_front();
            checked++;
            if ((prdata & x.m) !== (x.d & x.m) || pslverr !== x.e)
                fail($sformatf("addr %h got %h/%b want %h/%b", paddr, prdata, pslverr, x.d, x.e));
        end
    end
    // ceiling far above the roughly 520 cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail("timeout");
            results();
        end
    end
    initial begin
        {reset, psel, penable, pwrite, loadByte, armGo, tv} = 7'h40;
        {paddr, pwdata, newByte, armTarget} = 0;
        void'($urandom(41497));
        repeat (3) @(posedge mclk);
        reset <= 0;
        rd(FBP_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(FBP_OFS_STATUS, 32'h3F, 32'h0);
        xfer(12'h010, 0, 32'h0, 32'hFFFFFFFF, 32'h0, 1);
        xfer(12'h014, 1, 32'h5, 32'h0, 32'h0, 1);
        wr(FBP_OFS_PROTECT, 32'h0);
        rd(FBP_OFS_PROTECT, 32'hFF, 32'hFF);
        $display("registers done");
        for (int i = 0; i < 9; i++) begin
            b = (i == 8) ? 8'h79 + $urandom_range(0, 8'h85) :
                8'(64'h00777B79DEDFFEFF >> (8 * (7 - i)));
            setByte(b);
            rd(FBP_OFS_STATUS, 32'hFFFF0020, {2'h3, b, 6'h00, 10'h0, b <= 8'h77, 5'h0});
        end
        $display("start address done");
        wr(FBP_OFS_CTRL, 32'h3);
        rd(FBP_OFS_CTRL, 32'h3, 32'h0);
        wr(FBP_OFS_CTRL, 32'h1);
        wr(FBP_OFS_CTRL, 32'h3);
        rd(FBP_OFS_CTRL, 32'h3, 32'h1);
        wr(FBP_OFS_CTRL, 32'h0);
        $display("interlock done");
        seq(8'hFF, 16'hE000, 4'h1, 0, 1, 8'hFF);
        seq(8'h00, 16'hE000, 4'h1, 0, 1, 8'h00);
        seq(8'hFE, 16'hFF80, 4'h2, 0, 1, 8'hFE);
        seq(8'hFE, 16'hFF7F, 4'h1, 0, 1, 8'hFE);
        seq(8'hC0, 16'hF000, 4'h1, 0, 1, 8'hC0);
        seq(8'hC0, 16'hEFFF, 4'h2, 0, 1, 8'hC0);
        seq(8'hFF, 16'hE000, 4'h6, 0, 1, 8'hFF);
        seq(8'hFE, 16'hE000, 4'h6, 0, 1, 8'hFE);
        seq(8'hFE, 16'hFFBE, 4'h1, 0, 1, 8'hFE);
        seq(8'hFE, 16'hFFBE, 4'h1, 1, 1, 8'hFE);
        seq(8'hFF, 16'hE000, 4'h2, 0, 0, 8'hFF);
        seq(8'hFF, 16'hE000, 4'h1, 0, 1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            t = 16'hDE00 + 16'($urandom_range(0, 16'h21FF));
            seq(b, t, 4'($urandom_range(1, 2)), 0, 1, b);
        end
        $display("sequences done");
        tv <= 1;
        repeat (2) @(posedge mclk);
        #1 chk(monO, 1'b1, "monitor entry on");
        tv <= 0;
        repeat (2) @(posedge mclk);
        #1 chk(monO, 1'b0, "monitor entry off");
        $display("monitor entry done");
        results();
    end
endmodule : fbp_flash_protect_tb
